// *** test/test_bltc_core.sv ***
// self-checking bench of the timer core: register access, counting modes, flags
`include "bltc_params.svh"
`default_nettype none
module test_bltc_core;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } bltc_row_type;
    localparam logic [7:0] a_ctl = `BLTC_OFS_CTRL;
    localparam logic [7:0] a_cnt = `BLTC_OFS_COUNT;
    localparam logic [7:0] a_per = `BLTC_OFS_PERIOD;
    localparam logic [7:0] a_st  = `BLTC_OFS_STATUS;
    localparam logic [1:0] m_stop = bltc_pkg::BLTC_MODE_STOP;
    localparam logic [1:0] m_up   = bltc_pkg::BLTC_MODE_UP;
    localparam logic [1:0] m_cont = bltc_pkg::BLTC_MODE_CONT;
    localparam logic [1:0] m_updn = bltc_pkg::BLTC_MODE_UPDN;
    logic         pclk    = 1'b0;
    logic         presetn = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [7:0]   paddr   = 8'h00;
    logic [31:0]  pwdata  = 32'h0000_0000;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [3:0]   src     = 4'h0;
    logic         wrap_flag;
    logic         channel_event_flag;
    logic [15:0]  count_value;
    logic [31:0]  rd;
    logic         er;
    int           bad_count = 0;
    int           tests_run = 0;
    bltc_row_type rows [15];

    always #2.5 pclk = ~pclk;

    bltc_core DUT (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .aux_clock            (src[0]),
        .subsystem_clock      (src[1]),
        .external_timer_clock (src[2]),
        .internal_alt_clock   (src[3]),
        .wrap_flag            (wrap_flag),
        .channel_event_flag   (channel_event_flag),
        .count_value          (count_value)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("wrong value pready expected 1 seen %b", pready);
            tally_and_finish();
        end else begin
            rd = prdata;
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            // let the write settle before anyone looks at the outputs
            @(posedge pclk);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] p, input logic [1:0] s,
                                        input logic [1:0] l, input logic c);
        ctl = 32'h0000_0000;
        ctl[`BLTC_CTL_MODE_LSB +: 2] = m;
        ctl[`BLTC_CTL_PRE_LSB +: 2]  = p;
        ctl[`BLTC_CTL_SRC_LSB +: 2]  = s;
        ctl[`BLTC_CTL_LEN_LSB +: 2]  = l;
        ctl[`BLTC_CTL_CLEAR_BIT]     = c;
    endfunction

    // rising edges on one source, each well apart so the sampler sees every one
    task automatic tick(input int s, input int n);
        repeat (n) begin
            src[s] <= 1'b1;
            repeat (2) @(posedge pclk);
            src[s] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic state(input logic [15:0] c, input logic w, input logic ch);
        check("count_value", {16'h0000, count_value}, {16'h0000, c});
        check("wrap_flag", {31'h0, wrap_flag}, {31'h0, w});
        check("channel_event_flag", {31'h0, channel_event_flag}, {31'h0, ch});
    endtask

    task automatic cnt(input logic [15:0] c);
        check("count_value", {16'h0000, count_value}, {16'h0000, c});
    endtask

    initial begin
        rows = '{
            '{1'b1, a_ctl, 32'h0000_00C0, 32'h0, 1'b0}, '{1'b1, a_cnt, 32'h0000_01FF, 32'h0, 1'b0},
            '{1'b0, a_cnt, 32'h0, 32'h0000_00FF, 1'b0}, '{1'b1, a_ctl, 32'h0000_0080, 32'h0, 1'b0},
            '{1'b1, a_cnt, 32'h0000_FFFF, 32'h0, 1'b0}, '{1'b0, a_cnt, 32'h0, 32'h0000_03FF, 1'b0},
            '{1'b1, a_ctl, 32'h0000_0040, 32'h0, 1'b0}, '{1'b1, a_cnt, 32'h0000_FFFF, 32'h0, 1'b0},
            '{1'b0, a_cnt, 32'h0, 32'h0000_0FFF, 1'b0}, '{1'b1, a_ctl, 32'h0000_0000, 32'h0, 1'b0},
            '{1'b1, a_cnt, 32'h0000_ABCD, 32'h0, 1'b0}, '{1'b0, a_cnt, 32'h0, 32'h0000_ABCD, 1'b0},
            '{1'b0, a_st, 32'h0, 32'h0000_0004, 1'b0}, '{1'b1, 8'h10, 32'h0000_0001, 32'h0, 1'b1},
            '{1'b0, 8'h10, 32'h0, 32'h0000_0000, 1'b1}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        state(16'h0000, 1'b0, 1'b0);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) check("prdata", rd, rows[i].exp);
            check("pslverr", {31'h0, er}, {31'h0, rows[i].err});
        end
        $display("register table done");
        wreg(a_per, 32'h0000_0003);
        wreg(a_ctl, ctl(m_up, 2'b00, 2'b00, 2'b00, 1'b1));
        tick(0, 3);
        state(16'h0003, 1'b0, 1'b1);
        tick(0, 1);
        state(16'h0000, 1'b1, 1'b1);
        tick(0, 1);
        state(16'h0001, 1'b1, 1'b1);
        wreg(a_st, 32'h0000_0003);
        state(16'h0001, 1'b0, 1'b0);
        wreg(a_ctl, ctl(m_stop, 2'b00, 2'b00, 2'b00, 1'b0));
        wreg(a_cnt, 32'h0000_000A);
        wreg(a_ctl, ctl(m_up, 2'b00, 2'b00, 2'b00, 1'b0));
        tick(0, 1);
        cnt(16'h0000);
        $display("up mode done");
        for (int p = 0; p < 4; p++) begin
            wreg(a_ctl, ctl(m_cont, p[1:0], 2'b00, 2'b00, 1'b1));
            tick(0, (1 << p) - 1);
            cnt(16'h0000);
            tick(0, 1);
            cnt(16'h0001);
        end
        for (int s = 0; s < 4; s++) begin
            wreg(a_ctl, ctl(m_cont, 2'b00, s[1:0], 2'b00, 1'b1));
            tick((s + 1) % 4, 1);
            cnt(16'h0000);
            tick(s, 1);
            cnt(16'h0001);
            wreg(a_ctl, ctl(m_stop, 2'b00, s[1:0], 2'b00, 1'b0));
            tick(s, 1);
            cnt(16'h0001);
        end
        $display("prescale and source done");
        wreg(a_st, 32'h0000_0003);
        wreg(a_cnt, 32'h0000_00FE);
        wreg(a_ctl, ctl(m_cont, 2'b00, 2'b00, 2'b11, 1'b0));
        tick(0, 1);
        state(16'h00FF, 1'b0, 1'b0);
        tick(0, 1);
        state(16'h0000, 1'b1, 1'b0);
        $display("continuous mode done");
        wreg(a_st, 32'h0000_0003);
        wreg(a_per, 32'h0000_0002);
        wreg(a_ctl, ctl(m_updn, 2'b00, 2'b00, 2'b00, 1'b1));
        tick(0, 1);
        state(16'h0001, 1'b0, 1'b0);
        tick(0, 1);
        state(16'h0002, 1'b0, 1'b1);
        tick(0, 1);
        state(16'h0001, 1'b0, 1'b1);
        tick(0, 1);
        state(16'h0000, 1'b1, 1'b1);
        tick(0, 3);
        cnt(16'h0001);
        wreg(a_ctl, ctl(m_stop, 2'b00, 2'b00, 2'b00, 1'b0));
        apb(1'b0, a_st, 32'h0);
        check("status", rd, 32'h0000_0003);
        wreg(a_ctl, ctl(m_updn, 2'b00, 2'b00, 2'b00, 1'b0));
        tick(0, 1);
        cnt(16'h0000);
        wreg(a_ctl, ctl(m_stop, 2'b00, 2'b00, 2'b00, 1'b1));
        apb(1'b0, a_st, 32'h0);
        check("status", rd, 32'h0000_0007);
        $display("up/down mode done");
        wreg(a_st, 32'h0000_0003);
        wreg(a_per, 32'h0000_0000);
        wreg(a_ctl, ctl(m_up, 2'b00, 2'b00, 2'b00, 1'b0));
        tick(0, 2);
        state(16'h0000, 1'b0, 1'b0);
        wreg(a_per, 32'h0000_0004);
        tick(0, 2);
        cnt(16'h0002);
        wreg(a_per, 32'h0000_0008);
        tick(0, 3);
        state(16'h0005, 1'b0, 1'b0);
        $display("period load done");
        wreg(a_per, 32'h0000_0003);
        tick(0, 1);
        cnt(16'h0000);
        wreg(a_cnt, 32'h0000_0003);
        state(16'h0003, 1'b0, 1'b0);
        tick(0, 1);
        state(16'h0000, 1'b1, 1'b0);
        wreg(a_ctl, ctl(m_up, 2'b00, 2'b00, 2'b00, 1'b1) | 32'h0000_0200);
        apb(1'b0, a_ctl, 32'h0);
        check("ctrl", rd, 32'h0000_0201);
        wreg(a_per, 32'h0000_0005);
        tick(0, 4);
        cnt(16'h0000);
        tick(0, 4);
        cnt(16'h0004);
        $display("deferred load done");
        wreg(a_ctl, ctl(m_stop, 2'b00, 2'b00, 2'b11, 1'b1));
        wreg(a_per, 32'h0000_0100);
        wreg(a_cnt, 32'h0000_00FE);
        wreg(a_st, 32'h0000_0003);
        wreg(a_ctl, ctl(m_updn, 2'b00, 2'b00, 2'b11, 1'b0));
        tick(0, 2);
        state(16'h0000, 1'b1, 1'b0);
        wreg(a_per, 32'h0000_0004);
        wreg(a_ctl, ctl(m_updn, 2'b00, 2'b00, 2'b00, 1'b1));
        tick(0, 5);
        cnt(16'h0003);
        wreg(a_per, 32'h0000_0008);
        tick(0, 1);
        cnt(16'h0002);
        tick(0, 7);
        cnt(16'h0005);
        $display("period change done");
        presetn <= 1'b0;
        @(posedge pclk);
        state(16'h0000, 1'b0, 1'b0);
        presetn <= 1'b1;
        @(posedge pclk);
        state(16'h0000, 1'b0, 1'b0);
        apb(1'b0, a_ctl, 32'h0);
        check("ctrl", rd, 32'h0000_0000);
        apb(1'b0, a_st, 32'h0);
        check("status", rd, 32'h0000_0004);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/bltc_core.sv ***
// apb-controlled 16-bit timer core with selectable length, source and divider
//
// The register addresses and the APB register port were decided locally.
`include "bltc_params.svh"
`default_nettype none

// Notes on behaviour
// - count once per selected divided tick
// - clear zeroes count and divider, sets direction up
// - lengths 8/10/12/16 bits select maximum
// - short-length count writes are right-justified
// - count writes apply at once
// - four clock sources chosen by field
// - prescaler passes or divides by 2/4/8
// - advance only when mode nonzero and clocked
// - mode 00 stop, 01 up, 10 cont, 11 updown
// - up mode zero to period, then zero
// - up entry above period restarts at zero
// - up: channel flag at period, wrap after
// - immediate period load: reach or roll to zero
// - continuous wraps at maximum, sets wrap flag
// - updown counts up to period and down
// - updown period above maximum behaves continuous
// - direction is latched across stops
// - updown flags at period and 1-to-0
// - zero period stops up and updown (not cont); nonzero restarts up
// - only counting sets flags, never writes
// - load select 00 copies buffer at once
// - counting down, new period after zero
module bltc_core (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer clock sources, sampled on pclk
    input  wire logic        aux_clock,
    input  wire logic        subsystem_clock,
    input  wire logic        external_timer_clock,
    input  wire logic        internal_alt_clock,
    // status
    output logic             wrap_flag,
    output logic             channel_event_flag,
    output logic      [15:0] count_value
);
    bltc_pkg::bltc_ctrl_type   ctrl;
    logic [15:0]               period_latch;
    logic [15:0]               period_buffer;
    logic                      pending_load;
    logic                      up_dir;
    logic [2:0]                div_cnt;
    logic                      src_q;
    logic                      src_now;
    logic                      src_rise;
    logic                      tick;
    logic [15:0]               max_cnt;
    logic [15:0]               next_count;
    logic                      next_up_dir;
    logic                      set_wrap;
    logic                      set_chan;
    logic                      wr_en;
    logic                      rd_en;
    logic                      clear_req;
    logic                      stopped_zero;
    logic                      was_up;
    logic                      clr_wrap;
    logic                      clr_chan;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign clear_req = wr_en && paddr == `BLTC_OFS_CTRL && pwdata[`BLTC_CTL_CLEAR_BIT];
    assign clr_wrap = wr_en && paddr == `BLTC_OFS_STATUS && pwdata[`BLTC_ST_WRAP_BIT];
    assign clr_chan = wr_en && paddr == `BLTC_OFS_STATUS && pwdata[`BLTC_ST_CHAN_BIT];

    // source mux and edge detect
    always_comb begin
        case (ctrl.clock_source_select)
            2'b00:   src_now = aux_clock;
            2'b01:   src_now = subsystem_clock;
            2'b10:   src_now = external_timer_clock;
            default: src_now = internal_alt_clock;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 1'b0;
        end else begin
            src_q <= src_now;
        end
    end
    assign src_rise = src_now & ~src_q;

    // prescaler: tick on every 1/2/4/8 source rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
        end else if (clear_req) begin
            div_cnt <= 3'h0;
        end else if (src_rise && ctrl.mode_control != bltc_pkg::BLTC_MODE_STOP) begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    always_comb begin
        case (ctrl.prescale_select)
            2'b00:   tick = src_rise;
            2'b01:   tick = src_rise & (div_cnt[0] == 1'b1);
            2'b10:   tick = src_rise & (div_cnt[1:0] == 2'b11);
            default: tick = src_rise & (div_cnt == 3'h7);
        endcase
    end

    always_comb begin
        case (ctrl.length_select)
            2'b00:   max_cnt = `BLTC_MAX_16;
            2'b01:   max_cnt = `BLTC_MAX_12;
            2'b10:   max_cnt = `BLTC_MAX_10;
            default: max_cnt = `BLTC_MAX_8;
        endcase
    end

    assign stopped_zero = period_latch == 16'h0000;

    // counting step and event decode
    always_comb begin
        next_count  = count_value;
        next_up_dir = up_dir;
        set_wrap    = 1'b0;
        set_chan    = 1'b0;
        case (ctrl.mode_control)
            bltc_pkg::BLTC_MODE_UP: begin
                if (!stopped_zero) begin
                    if (count_value >= period_latch) begin
                        next_count = 16'h0000;
                        set_wrap   = count_value == period_latch;
                    end else begin
                        next_count = count_value + 16'h0001;
                        set_chan   = next_count == period_latch;
                    end
                    next_up_dir = 1'b1;
                end
            end
            bltc_pkg::BLTC_MODE_CONT: begin
                if (count_value >= max_cnt) begin
                    next_count = 16'h0000;
                    set_wrap   = 1'b1;
                end else begin
                    next_count = count_value + 16'h0001;
                end
            end
            bltc_pkg::BLTC_MODE_UPDN: begin
                if (period_latch > max_cnt) begin
                    next_up_dir = 1'b1;
                    if (count_value >= max_cnt) begin
                        next_count = 16'h0000;
                        set_wrap   = 1'b1;
                    end else begin
                        next_count = count_value + 16'h0001;
                    end
                end else if (!stopped_zero) begin
                    if (up_dir) begin
                        if (count_value >= period_latch) begin
                            next_up_dir = 1'b0;
                            next_count  = count_value - 16'h0001;
                        end else begin
                            next_count = count_value + 16'h0001;
                            set_chan   = next_count == period_latch;
                        end
                    end else if (count_value == 16'h0000) begin
                        next_up_dir = 1'b1;
                        next_count  = 16'h0001;
                    end else begin
                        next_count = count_value - 16'h0001;
                        set_wrap   = count_value == 16'h0001;
                        next_up_dir = count_value == 16'h0001;
                    end
                end
            end
            default: begin
                next_count = count_value;
            end
        endcase
        next_count = next_count & max_cnt;
    end

    // counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= 16'h0000;
        end else if (clear_req) begin
            count_value <= 16'h0000;
        end else if (wr_en && paddr == `BLTC_OFS_COUNT) begin
            count_value <= pwdata[15:0] & max_cnt;
        end else if (wr_en && paddr == `BLTC_OFS_PERIOD && stopped_zero && pwdata[15:0] != 16'h0000
                     && ctrl.period_load_select == 2'b00) begin
            count_value <= 16'h0000;
        end else if (tick) begin
            count_value <= next_count;
        end
    end

    // latched direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_dir <= 1'b1;
        end else if (clear_req) begin
            up_dir <= 1'b1;
        end else if (wr_en && paddr == `BLTC_OFS_PERIOD && stopped_zero && pwdata[15:0] != 16'h0000) begin
            up_dir <= 1'b1;
        end else if (tick) begin
            up_dir <= next_up_dir;
        end
    end

    // period buffer and latch; deferred loads apply at zero, down-count keeps old period
    assign was_up = up_dir;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_buffer <= 16'h0000;
            period_latch  <= 16'h0000;
            pending_load  <= 1'b0;
        end else if (wr_en && paddr == `BLTC_OFS_PERIOD) begin
            period_buffer <= pwdata[15:0];
            if (ctrl.period_load_select == 2'b00) begin
                period_latch <= pwdata[15:0];
                pending_load <= 1'b0;
            end else begin
                pending_load <= 1'b1;
            end
        end else if (pending_load && tick && next_count == 16'h0000) begin
            period_latch <= period_buffer;
            pending_load <= 1'b0;
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_flag          <= 1'b0;
            channel_event_flag <= 1'b0;
        end else begin
            if (tick && set_wrap) begin
                wrap_flag <= 1'b1;
            end else if (clr_wrap) begin
                wrap_flag <= 1'b0;
            end
            if (tick && set_chan) begin
                channel_event_flag <= 1'b1;
            end else if (clr_chan) begin
                channel_event_flag <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= bltc_pkg::bltc_ctrl_type'(`BLTC_CTL_RESET);
        end else if (wr_en && paddr == `BLTC_OFS_CTRL) begin
            // the clear bit is a pulse and is not stored, so the load select sits above it
            ctrl <= bltc_pkg::bltc_ctrl_type'({pwdata[10:9], pwdata[7:0]});
        end
    end

    // apb read path, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `BLTC_OFS_CTRL:   prdata <= {21'h0, ctrl.period_load_select, 1'b0, ctrl[7:0]};
                    `BLTC_OFS_COUNT:  prdata <= {16'h0000, count_value};
                    `BLTC_OFS_PERIOD: prdata <= {16'h0000, period_buffer};
                    `BLTC_OFS_STATUS: prdata <= {29'h0, was_up, channel_event_flag, wrap_flag};
                    default:          pslverr <= 1'b1;
                endcase
            end
        end
    end

    // assertions
    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (tick && !clear_req && !wr_en && ctrl.mode_control == bltc_pkg::BLTC_MODE_CONT && count_value < max_cnt)
        |=> count_value == $past(count_value) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        clear_req |=> count_value == 16'h0000 && div_cnt == 3'h0 && up_dir;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");

    property p_len;
        @(posedge pclk) disable iff (!presetn)
        $stable(ctrl.length_select) |-> (count_value & ~max_cnt) == 16'h0000 or $changed(ctrl.length_select);
    endproperty
    a_len: assert property (p_len) else $error("count beyond length");

    property p_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `BLTC_OFS_COUNT && !clear_req) |=> count_value == ($past(pwdata[15:0]) & $past(max_cnt));
    endproperty
    a_wr: assert property (p_wr) else $error("count write lost");

    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.mode_control == bltc_pkg::BLTC_MODE_STOP && !wr_en) |=> $stable(count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_wrapcont;
        @(posedge pclk) disable iff (!presetn)
        (tick && !wr_en && ctrl.mode_control == bltc_pkg::BLTC_MODE_CONT && count_value == max_cnt)
        |=> count_value == 16'h0000 && wrap_flag;
    endproperty
    a_wrapcont: assert property (p_wrapcont) else $error("continuous wrap wrong");

    property p_nowrite_flag;
        @(posedge pclk) disable iff (!presetn)
        (!tick && !wrap_flag) |=> !wrap_flag;
    endproperty
    a_nowrite_flag: assert property (p_nowrite_flag) else $error("flag set without count");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        (channel_event_flag && !clr_chan) |=> channel_event_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_imm;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `BLTC_OFS_PERIOD && ctrl.period_load_select == 2'b00)
        |=> period_latch == $past(pwdata[15:0]);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate load missed");

    property p_upwrap;
        @(posedge pclk) disable iff (!presetn)
        (tick && !wr_en && ctrl.mode_control == bltc_pkg::BLTC_MODE_UP && !stopped_zero
         && count_value == period_latch)
        |=> count_value == 16'h0000 && wrap_flag;
    endproperty
    a_upwrap: assert property (p_upwrap) else $error("up wrap wrong");

    property p_updn_chan;
        @(posedge pclk) disable iff (!presetn)
        (tick && !wr_en && ctrl.mode_control == bltc_pkg::BLTC_MODE_UPDN && up_dir && !stopped_zero
         && period_latch <= max_cnt && count_value == period_latch - 16'h0001)
        |=> count_value == $past(period_latch) && channel_event_flag;
    endproperty
    a_updn_chan: assert property (p_updn_chan) else $error("up/down period flag missed");

    property p_hold_dir;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.mode_control == bltc_pkg::BLTC_MODE_STOP && !wr_en) |=> $stable(up_dir);
    endproperty
    a_hold_dir: assert property (p_hold_dir) else $error("direction lost while stopped");

    property p_zero_stop;
        @(posedge pclk) disable iff (!presetn)
        (tick && !wr_en && stopped_zero && (ctrl.mode_control == bltc_pkg::BLTC_MODE_UP
         || ctrl.mode_control == bltc_pkg::BLTC_MODE_UPDN))
        |=> $stable(count_value);
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("count moved with zero period");
endmodule
`default_nettype wire

// *** verilog/bltc_params.svh ***
// offsets, field positions, reset values and counts of the timer core
`ifndef BLTC_PARAMS_SVH
`define BLTC_PARAMS_SVH

`define BLTC_ADDR_W        8
`define BLTC_OFS_CTRL      8'h00
`define BLTC_OFS_COUNT     8'h04
`define BLTC_OFS_PERIOD    8'h08
`define BLTC_OFS_STATUS    8'h0C

// control field positions
`define BLTC_CTL_MODE_LSB  0
`define BLTC_CTL_PRE_LSB   2
`define BLTC_CTL_SRC_LSB   4
`define BLTC_CTL_LEN_LSB   6
`define BLTC_CTL_CLEAR_BIT 8
`define BLTC_CTL_PLD_LSB   9
`define BLTC_CTL_RESET     10'h000

// status bits
`define BLTC_ST_WRAP_BIT   0
`define BLTC_ST_CHAN_BIT   1
`define BLTC_ST_DIR_BIT    2

// length maxima
`define BLTC_MAX_8         16'h00FF
`define BLTC_MAX_10        16'h03FF
`define BLTC_MAX_12        16'h0FFF
`define BLTC_MAX_16        16'hFFFF

`endif

// *** verilog/bltc_pkg.sv ***
// types of the timer core
`default_nettype none
package bltc_pkg;
    typedef enum logic [1:0] {
        BLTC_MODE_STOP = 2'b00,
        BLTC_MODE_UP   = 2'b01,
        BLTC_MODE_CONT = 2'b10,
        BLTC_MODE_UPDN = 2'b11
    } bltc_mode_type;

    typedef struct packed {
        logic [1:0]    period_load_select;
        logic [1:0]    length_select;
        logic [1:0]    clock_source_select;
        logic [1:0]    prescale_select;
        bltc_mode_type mode_control;
    } bltc_ctrl_type;

    typedef struct packed {
        logic up_dir;
        logic chan_flag;
        logic wrap_flag;
    } bltc_status_type;
endpackage
`default_nettype wire
